// file: cuh_exec_model.sv
// execution unit model that issues cache accesses on the access port
`timescale 1ns/1ps
module cuh_exec_model (
	input wire logic clk,
	output cuh_pkg::cuh_acc_t acc_o,
	input wire logic acc_done_i
);
	// ----------------------------------------
	// access request
	// ----------------------------------------
	initial begin
		acc_o = '0;
	end

	// fields held until done; released fields go inverted so no stale value passes
	task automatic access(input logic [6:0] line, input logic match, input logic [1:0] q, input int lim,
		output int n);
		begin
			@(posedge clk);
			acc_o <= '{valid: 1'b1, line: line, match: match, match_q: q};
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (acc_done_i !== 1'b1 && n < lim);
			acc_o <= '{valid: 1'b0, line: ~line, match: ~match, match_q: ~q};
		end
	endtask
endmodule

// file: cuh_pkg.sv
// shared constants, states and carrier types of the use-history and sweeper block
package cuh_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STAT = 4'h4;
	localparam logic [3:0] OFF_LUT = 4'h8;
	localparam logic [3:0] OFF_USE = 4'hc;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_PAGE_LSB = 0;
	localparam int CTRL_TYPE_LSB = 13;
	localparam int TY_ONE_PAGE = 0;
	localparam int TY_VAL_CORE = 1;
	localparam int TY_INVAL = 2;
	localparam int LUT_ADR_LSB = 0;
	localparam int LUT_DAT_LSB = 8;
	localparam int STAT_REQ_BIT = 0;
	localparam int STAT_CNT_LSB = 1;
	localparam int STAT_TYPE_LSB = 10;
	localparam int STAT_HOLD_BIT = 13;
	localparam int STAT_BUSY_BIT = 14;
	localparam int USE_MRU_LSB = 0;
	localparam int USE_ORD_BIT = 2;
	localparam int USE_LRU_LSB = 3;
	localparam int LUT_ORD_BIT = 0;
	localparam int LUT_LRU_LSB = 1;

	// ----------------------------------------
	// widths, load and reset values
	// ----------------------------------------
	localparam int PAGE_W = 13;
	localparam int CNT_W = 9;
	localparam int LINE_W = 7;
	localparam int USE_W = 5;
	localparam int LUT_W = 3;
	localparam int LUT_AW = 7;
	localparam logic [8:0] CNT_LOAD = 9'h1ff;
	localparam logic [8:0] CNT_RST = 9'h000;

	// counter select pair, written {select_two, select_one}
	localparam logic [1:0] SEL_LOAD = 2'b00;
	localparam logic [1:0] SEL_HOLD = 2'b11;
	localparam logic [1:0] SEL_DEC = 2'b01;

	// ----------------------------------------
	// cache control time states
	// ----------------------------------------
	typedef enum logic [8:0] {
		CUH_IDLE = 9'h001,
		CUH_PT0 = 9'h002,
		CUH_PT1 = 9'h004,
		CUH_PT2 = 9'h008,
		CUH_DC1 = 9'h010,
		CUH_DC2 = 9'h020,
		CUH_UPD = 9'h040,
		CUH_SW4 = 9'h080,
		CUH_SWR = 9'h100
	} cuh_state_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [6:0] line;
		logic match;
		logic [1:0] match_q;
	} cuh_acc_t;

	typedef struct packed {
		logic active;
		logic val_core;
		logic cycle;
		logic dir_clr;
		logic [21:0] addr;
	} cuh_sweep_t;

endpackage

// file: cuh_sweep_ctr.sv
// line and block sweep counter driven by the counter select pair
`timescale 1ns/1ps
module cuh_sweep_ctr (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] sel,
	input wire logic single_page,
	output logic [8:0] cnt,
	output logic carry
);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	logic [8:0] cnt_r;
	logic [8:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		case (sel)
			cuh_pkg::SEL_LOAD: cnt_nxt = cuh_pkg::CNT_LOAD;
			// a 9-bit borrow lets the block bits step the line bits
			cuh_pkg::SEL_DEC: begin
				if (single_page) begin
					cnt_nxt = {cnt_r[8:2] - 7'h01, cnt_r[1:0]};
				end else begin
					cnt_nxt = cnt_r - 9'h001;
				end
			end
			default: cnt_nxt = cnt_r;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= cuh_pkg::CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt = cnt_r;
	assign carry = single_page ? (cnt_r[8:2] == 7'h00) : (cnt_r == 9'h000);

endmodule

// file: cuh_top.sv
// cache use-history update and cache sweeper control with wishbone registers
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module cuh_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire cuh_pkg::cuh_acc_t acc_i,
	output logic acc_done_o,
	output cuh_pkg::cuh_sweep_t sweep_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	cuh_pkg::cuh_state_t state_r;
	cuh_pkg::cuh_state_t state_nxt;
	logic setup_r;
	logic match_hold_latch_r;
	logic [1:0] quarter_r;
	logic [6:0] acc_line_r;
	logic [12:0] page_r;
	logic sweep_single_page_r;
	logic sweep_validate_core_r;
	logic sweep_invalidate_cache_r;
	logic sweep_request_flop_r;
	logic sweep_cycle_done_r;
	logic setup_taken_r;
	logic wb_ack_r;
	logic [31:0] wb_dat_r;
	logic [6:0] peek_idx_r;
	logic wb_hit;
	logic ctrl_wr;
	logic setup_req;
	logic memory_response;
	logic sweep_register_load;
	logic [1:0] ctr_sel;
	logic counter_select_one;
	logic counter_select_two;
	logic [8:0] cnt;
	logic sweep_counter_carry;
	logic sweep_cyc;
	logic use_we;
	logic [6:0] use_idx;
	logic [1:0] use_quarter;
	logic [4:0] use_entry;
	logic [4:0] peek_entry;
	logic lut_we;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// wishbone decode
	// ----------------------------------------
	assign wb_hit = wb_cyc_i && wb_stb_i;
	assign ctrl_wr = wb_hit && wb_we_i && (wb_adr_i == cuh_pkg::OFF_CTRL);
	// a control write stays pending until the setup cycle answers it
	assign setup_req = ctrl_wr && !setup_taken_r;
	assign lut_we = wb_hit && wb_we_i && !wb_ack_r && (wb_adr_i == cuh_pkg::OFF_LUT);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_r <= 1'b0;
		end else if (wb_hit && !wb_ack_r) begin
			wb_ack_r <= ctrl_wr ? memory_response : 1'b1;
		end else begin
			wb_ack_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_taken_r <= 1'b0;
		end else if (wb_ack_r) begin
			setup_taken_r <= 1'b0;
		end else if (state_r == cuh_pkg::CUH_IDLE && state_nxt == cuh_pkg::CUH_PT0 && !acc_i.valid) begin
			setup_taken_r <= setup_req;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			peek_idx_r <= 7'h00;
		end else if (wb_hit && wb_we_i && !wb_ack_r && wb_adr_i == cuh_pkg::OFF_USE && wb_sel_i[0]) begin
			peek_idx_r <= wb_dat_i[6:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			cuh_pkg::OFF_CTRL: begin
				rd_mux[cuh_pkg::CTRL_PAGE_LSB +: 13] = page_r;
				rd_mux[cuh_pkg::CTRL_TYPE_LSB +: 3] = {sweep_invalidate_cache_r, sweep_validate_core_r,
					sweep_single_page_r};
			end
			cuh_pkg::OFF_STAT: begin
				rd_mux[cuh_pkg::STAT_REQ_BIT] = sweep_request_flop_r;
				rd_mux[cuh_pkg::STAT_CNT_LSB +: 9] = cnt;
				rd_mux[cuh_pkg::STAT_TYPE_LSB +: 3] = {sweep_invalidate_cache_r, sweep_validate_core_r,
					sweep_single_page_r};
				rd_mux[cuh_pkg::STAT_HOLD_BIT] = match_hold_latch_r;
				rd_mux[cuh_pkg::STAT_BUSY_BIT] = (state_r != cuh_pkg::CUH_IDLE);
			end
			cuh_pkg::OFF_USE: rd_mux[4:0] = peek_entry;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_r <= 32'h0000_0000;
		end else if (wb_hit && !wb_we_i && !wb_ack_r) begin
			wb_dat_r <= rd_mux;
		end
	end

	assign wb_ack_o = wb_ack_r;
	assign wb_dat_o = wb_dat_r;

	// ----------------------------------------
	// cache control time states
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cuh_pkg::CUH_IDLE: begin
				// sweeper yields to any processor request
				if (acc_i.valid || setup_req) begin
					state_nxt = cuh_pkg::CUH_PT0;
				end else if (sweep_request_flop_r && !sweep_cycle_done_r) begin
					state_nxt = cuh_pkg::CUH_SW4;
				end
			end
			cuh_pkg::CUH_PT0: state_nxt = cuh_pkg::CUH_PT1;
			cuh_pkg::CUH_PT1: state_nxt = cuh_pkg::CUH_PT2;
			cuh_pkg::CUH_PT2: begin
				if (setup_r) begin
					state_nxt = cuh_pkg::CUH_IDLE;
				end else if (acc_i.match) begin
					state_nxt = cuh_pkg::CUH_UPD;
				end else begin
					state_nxt = cuh_pkg::CUH_DC1;
				end
			end
			cuh_pkg::CUH_DC1: state_nxt = cuh_pkg::CUH_DC2;
			cuh_pkg::CUH_DC2: state_nxt = cuh_pkg::CUH_UPD;
			cuh_pkg::CUH_UPD: state_nxt = cuh_pkg::CUH_IDLE;
			cuh_pkg::CUH_SW4: begin
				state_nxt = sweep_invalidate_cache_r ? cuh_pkg::CUH_SWR : cuh_pkg::CUH_IDLE;
			end
			cuh_pkg::CUH_SWR: state_nxt = cuh_pkg::CUH_IDLE;
			default: state_nxt = cuh_pkg::CUH_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= cuh_pkg::CUH_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// access takes priority over setup when both arrive together
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_r <= 1'b0;
			acc_line_r <= 7'h00;
		end else if (state_r == cuh_pkg::CUH_IDLE && state_nxt == cuh_pkg::CUH_PT0) begin
			setup_r <= !acc_i.valid;
			acc_line_r <= acc_i.line;
		end
	end

	// ----------------------------------------
	// use history update
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			match_hold_latch_r <= 1'b0;
		end else if (state_r == cuh_pkg::CUH_PT0) begin
			match_hold_latch_r <= 1'b0;
		end else if (state_r == cuh_pkg::CUH_PT2 && !setup_r) begin
			match_hold_latch_r <= acc_i.match;
		end
	end

	// victim select gate opens only at data-clear t1 with the latch clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			quarter_r <= 2'b00;
		end else if (state_r == cuh_pkg::CUH_PT2 && acc_i.match) begin
			quarter_r <= acc_i.match_q;
		end else if (state_r == cuh_pkg::CUH_DC1 && !match_hold_latch_r) begin
			quarter_r <= use_entry[cuh_pkg::USE_LRU_LSB +: 2];
		end
	end

	assign sweep_cyc = (state_r == cuh_pkg::CUH_SW4) || (state_r == cuh_pkg::CUH_SWR);
	assign use_we = (state_r == cuh_pkg::CUH_UPD) || (state_r == cuh_pkg::CUH_SWR);
	// sweep: line counter addresses the entry, block bits force the quarter
	assign use_idx = sweep_cyc ? cnt[8:2] : acc_line_r;
	assign use_quarter = sweep_cyc ? cnt[1:0] : quarter_r;

	// new entry is {lookup word, quarter}: order and lru from lookup, mru from quarter
	cuh_use_hist u_hist (
		.clk(clk),
		.lut_we(lut_we),
		.lut_adr(wb_dat_i[cuh_pkg::LUT_ADR_LSB +: 7]),
		.lut_dat(wb_dat_i[cuh_pkg::LUT_DAT_LSB +: 3]),
		.use_we(use_we),
		.use_idx(use_idx),
		.quarter(use_quarter),
		.peek_idx(peek_idx_r),
		.use_entry(use_entry),
		.peek_entry(peek_entry)
	);

	assign acc_done_o = (state_r == cuh_pkg::CUH_UPD);

	// ----------------------------------------
	// sweeper setup and counters
	// ----------------------------------------
	assign sweep_register_load = (state_r == cuh_pkg::CUH_PT1) && setup_r;
	assign memory_response = (state_r == cuh_pkg::CUH_PT2) && setup_r;

	always_comb begin
		if (sweep_register_load) begin
			ctr_sel = cuh_pkg::SEL_LOAD;
		end else if (sweep_cycle_done_r) begin
			ctr_sel = cuh_pkg::SEL_DEC;
		end else begin
			ctr_sel = cuh_pkg::SEL_HOLD;
		end
	end

	assign counter_select_two = ctr_sel[1];
	assign counter_select_one = ctr_sel[0];

	// page and type come straight from the held write data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			page_r <= 13'h0000;
			sweep_single_page_r <= 1'b0;
			sweep_validate_core_r <= 1'b0;
			sweep_invalidate_cache_r <= 1'b0;
		end else if (sweep_register_load) begin
			page_r <= wb_dat_i[cuh_pkg::CTRL_PAGE_LSB +: 13];
			sweep_single_page_r <= wb_dat_i[cuh_pkg::CTRL_TYPE_LSB + cuh_pkg::TY_ONE_PAGE];
			sweep_validate_core_r <= wb_dat_i[cuh_pkg::CTRL_TYPE_LSB + cuh_pkg::TY_VAL_CORE];
			sweep_invalidate_cache_r <= wb_dat_i[cuh_pkg::CTRL_TYPE_LSB + cuh_pkg::TY_INVAL];
		end
	end

	cuh_sweep_ctr u_ctr (
		.clk(clk),
		.rst_b(rst_b),
		.sel({counter_select_two, counter_select_one}),
		.single_page(sweep_single_page_r),
		.cnt(cnt),
		.carry(sweep_counter_carry)
	);

	// a type with no operation bits leaves nothing to sweep
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sweep_request_flop_r <= 1'b0;
		end else if (sweep_register_load) begin
			sweep_request_flop_r <= wb_dat_i[cuh_pkg::CTRL_TYPE_LSB + cuh_pkg::TY_VAL_CORE] ||
				wb_dat_i[cuh_pkg::CTRL_TYPE_LSB + cuh_pkg::TY_INVAL];
		end else if (sweep_cycle_done_r && sweep_counter_carry) begin
			sweep_request_flop_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sweep_cycle_done_r <= 1'b0;
		end else begin
			sweep_cycle_done_r <= sweep_cyc && (state_nxt == cuh_pkg::CUH_IDLE);
		end
	end

	assign sweep_o.active = sweep_request_flop_r;
	assign sweep_o.val_core = sweep_validate_core_r;
	assign sweep_o.cycle = (state_r == cuh_pkg::CUH_SW4);
	assign sweep_o.dir_clr = (state_r == cuh_pkg::CUH_SWR);
	assign sweep_o.addr = {page_r, cnt};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_setup_load_count: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_register_load |-> ctr_sel == cuh_pkg::SEL_LOAD ##1 (cnt == 9'h1ff && !sweep_register_load))
		else $error("setup did not load count 777 for one clock");

	a_setup_resp_hold: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_register_load |=> memory_response && ctr_sel == cuh_pkg::SEL_HOLD)
		else $error("no response or hold after setup");

	a_done_decrement: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_cycle_done_r |-> {counter_select_two, counter_select_one} == 2'b01)
		else $error("cycle done without decrement select");

	a_done_one_clock: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(sweep_cycle_done_r) |=> !sweep_cycle_done_r)
		else $error("cycle done held beyond one clock");

	a_carry_ends_sweep: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_cycle_done_r && sweep_counter_carry |=> !sweep_request_flop_r && state_r != cuh_pkg::CUH_SW4)
		else $error("sweep request survived carry");

	a_inval_write_t4: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == cuh_pkg::CUH_SW4 && sweep_invalidate_cache_r |=> use_we && sweep_o.dir_clr &&
		use_quarter == cnt[1:0] && use_idx == cnt[8:2])
		else $error("invalidate sweep did not write one clock after t4");

	a_hit_update: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == cuh_pkg::CUH_PT2 && !setup_r && acc_i.match |=>
		use_we && match_hold_latch_r && quarter_r == $past(acc_i.match_q))
		else $error("hit did not update with matching quarter");

	a_miss_victim: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == cuh_pkg::CUH_PT2 && !setup_r && !acc_i.match |=>
		!match_hold_latch_r ##1 !use_we ##1 (use_we && quarter_r == $past(use_entry[4:3], 2)))
		else $error("miss did not update after data-clear t2 with victim");

	a_sweep_yields: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == cuh_pkg::CUH_IDLE && (acc_i.valid || setup_req) |=> state_r == cuh_pkg::CUH_PT0)
		else $error("sweep cycle granted over pending request");

	a_whole_step: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_cycle_done_r && !sweep_single_page_r |=> cnt == $past(cnt) - 9'h001)
		else $error("whole sweep did not step by one block");

	a_page_step: assert property (@(posedge clk) disable iff (!rst_b)
		sweep_cycle_done_r && sweep_single_page_r |=>
		cnt[8:2] == $past(cnt[8:2]) - 7'h01 && cnt[1:0] == $past(cnt[1:0]))
		else $error("single page sweep did not step the line");

endmodule

// file: cuh_use_hist.sv
// use table and replacement lookup table storage
`timescale 1ns/1ps
module cuh_use_hist (
	input wire logic clk,
	input wire logic lut_we,
	input wire logic [6:0] lut_adr,
	input wire logic [2:0] lut_dat,
	input wire logic use_we,
	input wire logic [6:0] use_idx,
	input wire logic [1:0] quarter,
	input wire logic [6:0] peek_idx,
	output logic [4:0] use_entry,
	output logic [4:0] peek_entry
);

	// ----------------------------------------
	// storage, no reset: contents come from sweeps and software
	// ----------------------------------------
	// use table starts at zero so its own lookups resolve before the first sweep
	logic [4:0] use_mem [0:127] = '{default: 5'h00};
	logic [2:0] lut_mem [0:127];
	logic [2:0] lut_rd;
	logic [4:0] peek_r;

	// quarter code forms the high lookup address bits
	assign use_entry = use_mem[use_idx];
	assign lut_rd = lut_mem[{quarter, use_entry}];

	always_ff @(posedge clk) begin
		if (lut_we) begin
			lut_mem[lut_adr] <= lut_dat;
		end
	end

	// lookup word fills order and least-recent, quarter fills most-recent
	always_ff @(posedge clk) begin
		if (use_we) begin
			use_mem[use_idx] <= {lut_rd, quarter};
		end
	end

	always_ff @(posedge clk) begin
		peek_r <= use_mem[peek_idx];
	end

	assign peek_entry = peek_r;

endmodule

// file: tb_cache_use_history_and_sweeper.sv
// self-checking bench for the use-history and sweeper block
`timescale 1ns/1ps
module tb_cache_use_history_and_sweeper;
	logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, acc_done_o, prev_cyc, first_seen;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [21:0] first_adr, last_adr;
	cuh_pkg::cuh_acc_t acc_i;
	cuh_pkg::cuh_sweep_t sweep_o;
	int err_count, n_tests, n_cyc, n_clr, n;

	cuh_top uut (
		.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .acc_i(acc_i), .acc_done_o(acc_done_o), .sweep_o(sweep_o)
	);
	cuh_exec_model u_exec (.clk(clk), .acc_o(acc_i), .acc_done_i(acc_done_o));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_sim();
		begin
			if (err_count == 0 && n_tests > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_tests++;
			if (got !== exp) begin
				err_count++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// classic single cycle; setup writes may take long, so the bound is generous
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
		int k;
		begin
			@(posedge clk);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= we;
			wb_adr_i <= adr;
			wb_dat_i <= dat;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (wb_ack_o !== 1'b1 && k < 4000);
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
			if (wb_ack_o !== 1'b1) begin
				err_count++;
				end_sim();
			end
		end
	endtask

	task automatic peek(input logic [6:0] idx, input logic [4:0] exp);
		begin
			wb(1'b1, cuh_pkg::OFF_USE, {25'h0, idx}, rd);
			wb(1'b0, cuh_pkg::OFF_USE, 32'h0, rd);
			check({27'h0, rd[4:0]}, {27'h0, exp});
		end
	endtask

	task automatic sweep(input logic [2:0] ty, input logic [12:0] pg, input int en, input int ec,
		input logic [8:0] last_cnt);
		int k;
		begin
			n_cyc = 0;
			n_clr = 0;
			first_seen = 1'b0;
			wb(1'b1, cuh_pkg::OFF_CTRL, {16'h0, ty, pg}, rd);
			check({31'h0, sweep_o.val_core}, {31'h0, ty[1]});
			check({31'h0, sweep_o.active}, {31'h0, ty[1] | ty[2]});
			wb(1'b0, cuh_pkg::OFF_CTRL, 32'h0, rd);
			check(rd, {16'h0, ty, pg});
			k = 0;
			do begin
				wb(1'b0, cuh_pkg::OFF_STAT, 32'h0, rd);
				k++;
			end while (rd[cuh_pkg::STAT_REQ_BIT] !== 1'b0 && k < 2000);
			check({31'h0, rd[cuh_pkg::STAT_REQ_BIT]}, 32'h0);
			check(32'(n_cyc), 32'(en));
			check(32'(n_clr), 32'(ec));
			check(32'(first_adr), 32'({pg, 9'h1ff}));
			check(32'(last_adr), 32'({pg, last_cnt}));
		end
	endtask

	// ----------------------------------------
	// sweep monitor
	// ----------------------------------------
	always @(posedge clk) begin
		prev_cyc <= sweep_o.cycle;
		if (sweep_o.cycle === 1'b1) begin
			n_cyc <= n_cyc + 1;
			last_adr <= sweep_o.addr;
			first_seen <= 1'b1;
			if (!first_seen) begin
				first_adr <= sweep_o.addr;
			end
		end
		if (sweep_o.dir_clr === 1'b1) begin
			n_clr <= n_clr + 1;
			check({31'h0, prev_cyc}, 32'h1);
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		err_count = 0;
		n_tests = 0;
		prev_cyc = 1'b0;
		first_seen = 1'b0;
		rst_b = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		check(32'(sweep_o), 32'h0);
		wb(1'b0, cuh_pkg::OFF_STAT, 32'h0, rd);
		check(rd, 32'h0);
		wb(1'b1, 4'h2, 32'hffff_ffff, rd);
		wb(1'b0, 4'h2, 32'h0, rd);
		check(rd, 32'h0);
		// uniform lookup word: entries converge even from unknown start contents
		for (int a = 0; a < 128; a++) begin
			wb(1'b1, cuh_pkg::OFF_LUT, {21'h0, 3'b110, 1'b0, 7'(a)}, rd);
		end
		sweep(3'b100, 13'h0, 512, 512, 9'h000);
		for (int l = 0; l < 128; l += 42) begin
			peek(7'(l), 5'h18);
		end
		// hit, quarter 2: lookup {2, 0x18}
		wb(1'b1, cuh_pkg::OFF_LUT, {21'h0, 3'b011, 1'b0, 7'd88}, rd);
		u_exec.access(7'd5, 1'b1, 2'd2, 50, n);
		check(32'(n), 32'h5);
		peek(7'd5, 5'h0e);
		wb(1'b0, cuh_pkg::OFF_STAT, 32'h0, rd);
		check({31'h0, rd[cuh_pkg::STAT_HOLD_BIT]}, 32'h1);
		// miss: victim is least-recent quarter 3, lookup {3, 0x18}
		wb(1'b1, cuh_pkg::OFF_LUT, {21'h0, 3'b100, 1'b0, 7'd120}, rd);
		u_exec.access(7'd9, 1'b0, 2'd1, 50, n);
		check(32'(n), 32'h7);
		peek(7'd9, 5'h13);
		wb(1'b0, cuh_pkg::OFF_STAT, 32'h0, rd);
		check({31'h0, rd[cuh_pkg::STAT_HOLD_BIT]}, 32'h0);
		sweep(3'b010, 13'h0c3, 512, 0, 9'h000);
		sweep(3'b101, 13'h1a5, 128, 128, 9'h003);
		wb(1'b1, cuh_pkg::OFF_CTRL, {16'h0, 3'b001, 13'h0}, rd);
		wb(1'b0, cuh_pkg::OFF_STAT, 32'h0, rd);
		check({31'h0, rd[cuh_pkg::STAT_REQ_BIT]}, 32'h0);
		check({31'h0, sweep_o.active}, 32'h0);
		end_sim();
	end
endmodule
